// >>> logic/srp_regs.svh
// Shared constants for the serial register port and its controller
`ifndef SRP_REGS_SVH
`define SRP_REGS_SVH
`define SRP_CLK_HZ 25000000
`define SRP_POR_HOLD_MS 250
`define SRP_NUM_LOC 91
`define SRP_CFG_RST 8'h00
`define SRP_A_ID_LO 7'h00
`define SRP_A_ID_HI 7'h01
`define SRP_A_REV 7'h02
`define SRP_A_STS_SRC 7'h05
`define SRP_A_STS_OP 7'h06
`define SRP_A_FRQ_HI 7'h07
`define SRP_A_STS_SYN 7'h08
`define SRP_A_OPMODE 7'h09
`define SRP_A_FRQ_LO 7'h0C
`define SRP_A_FRQ_MID 7'h0D
`define SRP_A_CFG_FIRST 7'h10
`define SRP_A_STRAP 7'h54
`define SRP_A_MW_LO 7'h55
`define SRP_A_MW_HI 7'h56
`define SRP_A_MSK_SRC 7'h57
`define SRP_A_MSK_OP 7'h58
`define SRP_A_MSK_SYN 7'h59
`define SRP_A_IRQ_CTL 7'h5A
`define SRP_IRQ_POL_BIT 0
`define SRP_IRQ_DRV_BIT 1
`define SRP_IRQ_CTL_USED 8'h03
`define SRP_OP_CHG_BIT 7
`define SRP_SEL_LOST_BIT 0
`define SRP_SYN_BIT 7
`define SRP_RW_IDX 5'h07
`define SRP_DATA_FIRST 5'h08
`define SRP_DATA_LAST 5'h0F
`define SRP_FRAME_BITS 5'h10
`define SRP_RW_READ 1'b1
`define SRP_SCLK_HALF 8
`define SRP_H_ADDR 2'h0
`define SRP_H_WDATA 2'h1
`define SRP_H_CTRL 2'h2
`define SRP_H_RDATA 2'h3
`define SRP_H_GO_BIT 0
`define SRP_H_RD_BIT 1
`define SRP_H_SEL_BIT 2
`endif

// >>> logic/srp_pkg.sv
// Types shared by both ends of the serial register port
`default_nettype none
package srp_pkg;
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SHIFT = 2'b01,
        H_END = 2'b10
    } srp_hst_e;
endpackage : srp_pkg
`default_nettype wire

// >>> logic/srp_if.sv
// Serial port wires between host and device
`timescale 1ns/100ps
`default_nettype none
interface srp_if;
    logic sclk;
    logic cs_n;
    logic serial_data_in;
    logic edge_sel;
    logic sdo_o;
    logic sdo_oe;
    logic irq_o;
    logic irq_oe;
    logic sdo_line;
    logic irq_line;
    // Pull-ups resolve released pins
    assign sdo_line = sdo_oe ? sdo_o : 1'b1;
    assign irq_line = irq_oe ? irq_o : 1'b1;
    modport dev (input sclk, cs_n, serial_data_in, edge_sel,
                 output sdo_o, sdo_oe, irq_o, irq_oe);
    modport host (output sclk, cs_n, serial_data_in, edge_sel,
                  input sdo_line, irq_line);
endinterface : srp_if
`default_nettype wire

// >>> logic/srp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module srp_sync #(
    parameter int W = 1
) (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst_b, // Async reset, active low
    input wire logic [W-1:0] i_d, // Asynchronous input
    output logic [W-1:0] o_q // Synchronised output
);
    logic [W-1:0] meta_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= '0;
            o_q <= '0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule : srp_sync
`default_nettype wire

// >>> logic/srp_device.sv
// Device end: serial register port, status, interrupt pin
// Contract
// - Reset pin low resets all registers async
// - Stay in reset 250 ms after release
// - Address and data shift LSB first
// - Capture serial input on rising clock edge
// - Edge select low: rising, high: falling
// - Host samples read data on falling edge; the host samples on the rising edge when edge select is high
// - No serial clock needed while deselected
// - Ninety-one byte register locations
// - Don't care bits have no effect
// - Host programs fixed bits after reset
// - Host never writes undefined addresses
// - Multi-byte write commits only uninterrupted
// - Reading one byte freezes the others
// - Host always writes whole bytes
// - Status: write one clears, zero keeps
// - Config defaults, strap defaults, all readable
// - Status read via shadow, writes clear
// - Interrupt pin polarity and drive programmable
// - Source, state and loss events set status
// - Mask bit one enables each source
// - Pin inactive once unmasked status cleared
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "srp_regs.svh"
module srp_device
    import srp_pkg::*;
#(
    parameter int POR_HOLD_CYC =
        `SRP_POR_HOLD_MS * (`SRP_CLK_HZ / 1000),
    parameter logic [7:0] ID_LO = 8'hA5, // Arbitrary value
    parameter logic [7:0] ID_HI = 8'h3C, // Arbitrary value
    parameter logic [7:0] REV = 8'h01 // Arbitrary value
) (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst_b, // Power-on reset, active low
    srp_if.dev lnk, // Serial port pins
    input wire logic [3:0] i_strap, // Default-setting pins
    input wire logic [7:0] i_src_valid, // Clock input valid levels
    input wire logic [2:0] i_op_state, // Operating state
    input wire logic i_sel_lost, // Selected input lost pulse
    input wire logic i_sync_alarm, // Sync alarm pulse
    input wire logic [18:0] i_freq, // Live frequency word
    output logic o_ready, // Internal reset over
    output logic [15:0] o_mw_value // Committed two-byte value
);
    localparam int HW = $clog2(POR_HOLD_CYC + 1);
    localparam logic [HW-1:0] HOLD_END = HW'(POR_HOLD_CYC - 1);

    logic [7:0] sync_out;
    logic sclk_s, cs_n_s, sdi_s, sel_s;
    logic [3:0] strap_s;
    logic [HW-1:0] hold_q;
    logic ready_q;
    logic sclk_p_q, cs_p_q;
    logic [4:0] cnt_q;
    logic [6:0] addr_q;
    logic rw_q;
    logic [7:0] wsh_q, rsh_q, rd_mux;
    logic [18:0] frz_q, fsrc;
    logic frz_v_q;
    logic [2:0] frz_seen_q;
    logic [7:0] st_src_q, st_op_q, st_syn_q;
    logic [7:0] src_p_q;
    logic [2:0] op_p_q;
    logic [7:0] mw_lo_q;
    logic mw_pend_q;
    logic [7:0] cfg_q [0:`SRP_NUM_LOC-1];
    logic rise, fall, cs_act, frame_end, in_data, out_ev, load;
    logic wr_commit;
    logic irq_pend, pol, drv;

    srp_sync #(.W(8)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_d({i_strap, lnk.edge_sel, lnk.serial_data_in, lnk.cs_n, lnk.sclk}),
        .o_q(sync_out)
    );
    assign {strap_s, sel_s, sdi_s, cs_n_s, sclk_s} = sync_out;

    function automatic logic [7:0] w1c(input logic [7:0] st,
                                       input logic [7:0] set,
                                       input logic [7:0] clr);
        // Set wins over a clear in the same cycle
        w1c = (st & ~clr) | set;
    endfunction : w1c

    function automatic logic [7:0] clr_of(input logic [6:0] a,
                                          input logic [6:0] reg_a,
                                          input logic hit,
                                          input logic [7:0] d);
        clr_of = (hit && a == reg_a) ? d : 8'h00;
    endfunction : clr_of

    assign rise = sclk_s & ~sclk_p_q;
    assign fall = ~sclk_s & sclk_p_q;
    assign cs_act = ~cs_n_s & ready_q;
    assign frame_end = cs_p_q & ~cs_act;
    assign in_data = cnt_q >= `SRP_DATA_FIRST && cnt_q <= `SRP_DATA_LAST;
    // Same count window serves both edges: falling follows its rise
    assign out_ev = cs_act && rw_q == `SRP_RW_READ && in_data &&
                    (sel_s ? fall : rise);
    assign load = cs_act && rise && cnt_q == `SRP_RW_IDX;
    assign wr_commit = frame_end && cnt_q == `SRP_FRAME_BITS &&
                       rw_q != `SRP_RW_READ;
    assign fsrc = frz_v_q ? frz_q : i_freq;

    // Internal reset stretch after the reset pin rises
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hold_q <= '0;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            hold_q <= hold_q + 1'b1;
            ready_q <= hold_q == HOLD_END;
        end
    end
    assign o_ready = ready_q;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_p_q <= 1'b0;
            cs_p_q <= 1'b0;
        end else begin
            sclk_p_q <= sclk_s;
            cs_p_q <= cs_act;
        end
    end

    // Frame shifter; idles on chip select alone, no clock needed
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= '0;
            addr_q <= '0;
            rw_q <= 1'b0;
            wsh_q <= '0;
        end else if (!cs_act) begin
            cnt_q <= '0;
        end else if (rise && cnt_q != `SRP_FRAME_BITS) begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q < `SRP_RW_IDX) begin
                addr_q <= {sdi_s, addr_q[6:1]};
            end else if (cnt_q == `SRP_RW_IDX) begin
                rw_q <= sdi_s;
            end else begin
                wsh_q <= {sdi_s, wsh_q[7:1]};
            end
        end
    end

    // Read byte is snapshotted at the read/write bit: shadow copy
    always_comb begin
        unique case (addr_q)
            `SRP_A_ID_LO: rd_mux = ID_LO;
            `SRP_A_ID_HI: rd_mux = ID_HI;
            `SRP_A_REV: rd_mux = REV;
            `SRP_A_STS_SRC: rd_mux = st_src_q;
            `SRP_A_STS_OP: rd_mux = st_op_q;
            `SRP_A_STS_SYN: rd_mux = st_syn_q;
            `SRP_A_OPMODE: rd_mux = {5'h00, i_op_state};
            `SRP_A_FRQ_LO: rd_mux = fsrc[7:0];
            `SRP_A_FRQ_MID: rd_mux = fsrc[15:8];
            `SRP_A_FRQ_HI: rd_mux = {5'h00, fsrc[18:16]};
            default: rd_mux = (addr_q < 7'(`SRP_NUM_LOC)) ?
                              cfg_q[addr_q] : 8'h00;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rsh_q <= '0;
        end else if (load) begin
            rsh_q <= rd_mux;
        end else if (out_ev) begin
            rsh_q <= {1'b0, rsh_q[7:1]};
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lnk.sdo_o <= 1'b0;
            lnk.sdo_oe <= 1'b0;
        end else if (!cs_act) begin
            lnk.sdo_o <= 1'b0;
            lnk.sdo_oe <= 1'b0;
        end else if (out_ev) begin
            lnk.sdo_o <= rsh_q[0];
            lnk.sdo_oe <= 1'b1;
        end
    end

    // Frequency word freeze across its three bytes
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            frz_q <= '0;
            frz_v_q <= 1'b0;
            frz_seen_q <= '0;
        end else if (load) begin
            if (sdi_s == `SRP_RW_READ &&
                (addr_q == `SRP_A_FRQ_LO || addr_q == `SRP_A_FRQ_MID ||
                 addr_q == `SRP_A_FRQ_HI)) begin
                logic [2:0] seen;
                seen = (frz_v_q ? frz_seen_q : 3'h0) |
                       {addr_q == `SRP_A_FRQ_HI,
                        addr_q == `SRP_A_FRQ_MID,
                        addr_q == `SRP_A_FRQ_LO};
                if (!frz_v_q) begin
                    frz_q <= i_freq;
                end
                frz_v_q <= seen != 3'h7;
                frz_seen_q <= seen;
            end else begin
                frz_v_q <= 1'b0;
            end
        end
    end

    // Sticky interrupt status, cleared by writing ones
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_src_q <= '0;
            st_op_q <= '0;
            st_syn_q <= '0;
            src_p_q <= '0;
            op_p_q <= '0;
        end else if (!ready_q) begin
            st_src_q <= '0;
            st_op_q <= '0;
            st_syn_q <= '0;
            src_p_q <= i_src_valid;
            op_p_q <= i_op_state;
        end else begin
            src_p_q <= i_src_valid;
            op_p_q <= i_op_state;
            st_src_q <= w1c(st_src_q, i_src_valid ^ src_p_q,
                clr_of(addr_q, `SRP_A_STS_SRC, wr_commit,
                       wsh_q));
            st_op_q <= w1c(st_op_q,
                {op_p_q != i_op_state, 6'h00, i_sel_lost},
                clr_of(addr_q, `SRP_A_STS_OP, wr_commit,
                       wsh_q));
            st_syn_q <= w1c(st_syn_q, {i_sync_alarm, 7'h00},
                clr_of(addr_q, `SRP_A_STS_SYN, wr_commit,
                       wsh_q));
        end
    end

    // Configuration store with uninterrupted two-byte commit
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < `SRP_NUM_LOC; i++) begin
                cfg_q[i] <= `SRP_CFG_RST;
            end
            mw_lo_q <= '0;
            mw_pend_q <= 1'b0;
        end else if (!ready_q) begin
            cfg_q[`SRP_A_STRAP] <= {4'h0, strap_s};
        end else if (frame_end) begin
            mw_pend_q <= wr_commit && addr_q == `SRP_A_MW_LO;
            if (wr_commit && addr_q == `SRP_A_MW_LO) begin
                mw_lo_q <= wsh_q;
            end else if (wr_commit && addr_q == `SRP_A_MW_HI) begin
                if (mw_pend_q) begin
                    cfg_q[`SRP_A_MW_LO] <= mw_lo_q;
                    cfg_q[`SRP_A_MW_HI] <= wsh_q;
                end
            end else if (wr_commit && addr_q == `SRP_A_IRQ_CTL) begin
                cfg_q[addr_q] <= wsh_q & `SRP_IRQ_CTL_USED;
            end else if (wr_commit && addr_q >= `SRP_A_CFG_FIRST &&
                         addr_q < 7'(`SRP_NUM_LOC)) begin
                cfg_q[addr_q] <= wsh_q;
            end
        end
    end
    assign o_mw_value = {cfg_q[`SRP_A_MW_HI], cfg_q[`SRP_A_MW_LO]};

    assign irq_pend = |(st_src_q & cfg_q[`SRP_A_MSK_SRC]) |
                      |(st_op_q & cfg_q[`SRP_A_MSK_OP]) |
                      |(st_syn_q & cfg_q[`SRP_A_MSK_SYN]);
    assign pol = cfg_q[`SRP_A_IRQ_CTL][`SRP_IRQ_POL_BIT];
    assign drv = cfg_q[`SRP_A_IRQ_CTL][`SRP_IRQ_DRV_BIT];

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lnk.irq_o <= 1'b0;
            lnk.irq_oe <= 1'b0;
        end else if (irq_pend) begin
            lnk.irq_o <= pol;
            lnk.irq_oe <= 1'b1;
        end else begin
            lnk.irq_o <= ~pol;
            lnk.irq_oe <= drv;
        end
    end
endmodule : srp_device
`default_nettype wire

// >>> logic/srp_host.sv
// Host end: serial port master driven by a small register port
`timescale 1ns/100ps
`default_nettype none
`include "srp_regs.svh"
module srp_host
    import srp_pkg::*;
#(
    parameter int HALF = `SRP_SCLK_HALF
) (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst_b, // Async reset, active low
    srp_if.host lnk, // Serial port pins
    input wire logic [1:0] i_addr, // Register address
    input wire logic [7:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [7:0] o_rdata, // Read data, cycle after strobe
    output logic o_irq_line // Synchronised interrupt pin level
);
    localparam logic [3:0] HALF_END = 4'(HALF - 1);

    srp_hst_e st_q;
    logic [1:0] sync_out;
    logic sdo_s;
    logic [6:0] addr_q;
    logic [7:0] wdata_q, rdata_q;
    logic sel_q, rd_q;
    logic [3:0] half_q;
    logic [4:0] nrise_q;
    logic [15:0] frame_q;
    logic tick, go;

    srp_sync #(.W(2)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_d({lnk.irq_line, lnk.sdo_line}),
        .o_q(sync_out)
    );
    assign sdo_s = sync_out[0];
    assign o_irq_line = sync_out[1];

    assign tick = half_q == HALF_END;
    assign go = i_wr && i_addr == `SRP_H_CTRL &&
                i_wdata[`SRP_H_GO_BIT] && st_q == H_IDLE;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            addr_q <= '0;
            wdata_q <= '0;
            sel_q <= 1'b0;
            rd_q <= 1'b0;
        end else if (i_wr && st_q == H_IDLE) begin
            if (i_addr == `SRP_H_ADDR) begin
                addr_q <= i_wdata[6:0];
            end
            if (i_addr == `SRP_H_WDATA) begin
                wdata_q <= i_wdata;
            end
            if (i_addr == `SRP_H_CTRL) begin
                sel_q <= i_wdata[`SRP_H_SEL_BIT];
                rd_q <= i_wdata[`SRP_H_RD_BIT];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            unique case (i_addr)
                `SRP_H_ADDR: o_rdata <= {1'b0, addr_q};
                `SRP_H_WDATA: o_rdata <= wdata_q;
                `SRP_H_CTRL: o_rdata <= {5'h00, sel_q, rd_q,
                                         st_q != H_IDLE};
                `SRP_H_RDATA: o_rdata <= rdata_q;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

    // Clock divider and frame sequencer
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= H_IDLE;
            half_q <= '0;
            nrise_q <= '0;
            frame_q <= '0;
            rdata_q <= '0;
            lnk.sclk <= 1'b0;
            lnk.cs_n <= 1'b1;
            lnk.serial_data_in <= 1'b0;
            lnk.edge_sel <= 1'b0;
        end else begin
            lnk.edge_sel <= sel_q;
            half_q <= (st_q == H_IDLE || tick) ? 4'h0 : half_q + 1'b1;
            unique case (st_q)
                H_IDLE: begin
                    if (go) begin
                        // Address, read/write, data; LSB first
                        frame_q <= {1'b0, wdata_q,
                            i_wdata[`SRP_H_RD_BIT], addr_q[6:1]};
                        lnk.serial_data_in <= addr_q[0];
                        lnk.cs_n <= 1'b0;
                        nrise_q <= '0;
                        st_q <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (tick) begin
                        lnk.sclk <= ~lnk.sclk;
                        if (!lnk.sclk) begin
                            nrise_q <= nrise_q + 1'b1;
                            if (sel_q && nrise_q >= `SRP_DATA_FIRST) begin
                                rdata_q <= {sdo_s, rdata_q[7:1]};
                            end
                        end else begin
                            if (!sel_q && nrise_q > `SRP_DATA_FIRST) begin
                                rdata_q <= {sdo_s, rdata_q[7:1]};
                            end
                            if (nrise_q == `SRP_FRAME_BITS) begin
                                st_q <= H_END;
                            end else begin
                                lnk.serial_data_in <= frame_q[0];
                                frame_q <= {1'b0, frame_q[15:1]};
                            end
                        end
                    end
                end
                H_END: begin
                    if (tick) begin
                        lnk.cs_n <= 1'b1;
                        lnk.serial_data_in <= 1'b0;
                        st_q <= H_IDLE;
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end
endmodule : srp_host
`default_nettype wire

// >>> tb/srp_lnk_properties.sv
// Concurrent checks on the serial port wires
`timescale 1ns/100ps
`default_nettype none
module srp_lnk_properties (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst_b, // Reset, active low
    input wire logic sclk, // Serial clock
    input wire logic cs_n, // Select, active low
    input wire logic serial_data_in, // Data to device
    input wire logic edge_sel, // Output edge select
    input wire logic sdo_o, // Data from device
    input wire logic sdo_oe // Device drives data
);
    logic sclk_q;
    logic rose_q;
    logic [3:0] age_q;
    logic [4:0] nrise_q;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) sclk_q <= 1'b0;
        else sclk_q <= sclk;
    end
    // Saturates so idle gaps never wrap
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            age_q <= 4'hF;
            rose_q <= 1'b0;
        end else if (sclk != sclk_q) begin
            age_q <= 4'h0;
            rose_q <= sclk;
        end else if (age_q != 4'hF) begin
            age_q <= age_q + 4'h1;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) nrise_q <= 5'h00;
        else if (cs_n) nrise_q <= 5'h00;
        else if (sclk && !sclk_q) nrise_q <= nrise_q + 5'h01;
    end
    sequence s_idle;
        cs_n [*8];
    endsequence
    a_sdo_edge: assert property (
        sdo_oe && $past(sdo_oe) && $changed(sdo_o)
        |-> age_q <= 4'h5 && rose_q == !edge_sel)
        else $error("sdo moved off its edge");
    a_sdo_late: assert property (
        $rose(sdo_oe) |-> !cs_n && nrise_q >= 5'h08)
        else $error("sdo driven too early");
    a_sdo_release: assert property (
        $rose(cs_n) |-> ##[0:5] !sdo_oe)
        else $error("sdo not released");
    a_sdo_idle: assert property (
        s_idle |-> !sdo_oe)
        else $error("sdo driven while idle");
    a_rise_count: assert property (
        $rose(cs_n) |-> nrise_q == 5'h10)
        else $error("frame rise count wrong");
    a_sclk_still: assert property (
        cs_n && $past(cs_n) |-> !sclk)
        else $error("sclk runs while idle");
    a_sdi_hold: assert property (
        sclk |-> $stable(serial_data_in))
        else $error("sdi moved while sclk high");
    a_sclk_half: assert property (
        $changed(sclk) |=> $stable(sclk) [*7])
        else $error("sclk half period short");
endmodule : srp_lnk_properties
`default_nettype wire

// >>> tb/tb.sv
// Bench joining host and device ends of the serial port
`timescale 1ns/100ps
`default_nettype none
`include "srp_regs.svh"
`define CHK(nm, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        $display("[ERR] %s exp %h got %h", nm, e, g); \
        n_fail++; \
    end \
end
module tb;
    localparam logic [7:0] ID_LO = 8'hA5; // Arbitrary value
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic [1:0] i_addr = 2'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [2:0] op_st = 3'h0;
    logic lost = 1'b0;
    logic alarm = 1'b0;
    logic [7:0] src = 8'h00;
    logic [18:0] freq = 19'h12345;
    logic [7:0] rdata;
    logic irq;
    logic ready;
    logic [15:0] mw;
    logic [15:0] cap = 16'h0000;
    int nb = 0;
    int n_fail = 0;
    int compares = 0;
    always #20 i_clk_sys = ~i_clk_sys;
    srp_if lnk ();
    srp_device #(.POR_HOLD_CYC(20), .ID_LO(ID_LO)) i_srp_device (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .lnk(lnk.dev),
        .i_strap(4'h5), .i_src_valid(src), .i_op_state(op_st),
        .i_sel_lost(lost), .i_sync_alarm(alarm), .i_freq(freq),
        .o_ready(ready), .o_mw_value(mw));
    srp_host i_srp_host (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .lnk(lnk.host),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(rdata), .o_irq_line(irq));
    srp_lnk_properties i_srp_lnk_properties (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .sclk(lnk.sclk),
        .cs_n(lnk.cs_n), .serial_data_in(lnk.serial_data_in), .edge_sel(lnk.edge_sel),
        .sdo_o(lnk.sdo_o), .sdo_oe(lnk.sdo_oe));
    // Bits in wire order, to see the shift order
    always @(posedge lnk.sclk or negedge lnk.cs_n) begin
        if (!lnk.sclk) begin
            nb = 0;
        end else if (!lnk.cs_n) begin
            if (nb < 16) cap[nb] = lnk.serial_data_in;
            nb++;
        end
    end
    task automatic final_report;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    task automatic timed_out(input string what);
        $display("[ERR] %s exp done got timeout", what);
        n_fail++;
        final_report();
    endtask : timed_out
    task automatic bw(input logic [1:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        @(posedge i_clk_sys);
    endtask : bw
    task automatic br(input logic [1:0] a, output logic [7:0] d);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 d = rdata;
        @(posedge i_clk_sys);
    endtask : br
    task automatic acc(input logic [6:0] a, input logic [7:0] d,
            input logic rd, input logic es, output logic [7:0] q);
        logic [7:0] s;
        int n;
        s = 8'h01;
        n = 0;
        bw(2'h0, {1'b0, a});
        bw(2'h1, d);
        bw(2'h2, {5'h00, es, rd, 1'b1});
        while (s[0] !== 1'b0) begin
            br(2'h2, s);
            n++;
            if (n > 400) timed_out("frame");
        end
        br(2'h3, q);
        `CHK("rises", 16, nb);
        `CHK("addr wire", {rd, a}, cap[7:0]);
        if (!rd) `CHK("data wire", d, cap[15:8]);
    endtask : acc
    // Trailing wait lets the pin synchroniser settle
    // Only mapped addresses are ever written
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(a, d, 1'b0, 1'b0, q);
        repeat (6) @(posedge i_clk_sys);
    endtask : wr
    task automatic boot;
        int n;
        n = 0;
        while (ready !== 1'b1) begin
            @(posedge i_clk_sys);
            #1 n = n + 1;
            if (n > 100) timed_out("ready");
        end
        `CHK("stretch", 1'b1, n >= 19 && n <= 22);
        @(posedge i_clk_sys);
    endtask : boot
    task automatic t_regs;
        logic [7:0] q;
        wr(7'h10, 8'hC3);
        acc(7'h10, 8'h00, 1'b1, 1'b0, q);
        `CHK("cfg", 8'hC3, q);
        acc(7'h10, 8'h00, 1'b1, 1'b1, q);
        `CHK("cfg fall", 8'hC3, q);
        wr(`SRP_A_ID_LO, 8'hFF);
        acc(`SRP_A_ID_LO, 8'h00, 1'b1, 1'b0, q);
        `CHK("id", ID_LO, q);
        acc(7'h5B, 8'h00, 1'b1, 1'b0, q);
        `CHK("unmapped", 8'h00, q);
    endtask : t_regs
    task automatic t_multi;
        logic [7:0] q;
        wr(`SRP_A_MW_LO, 8'h11);
        wr(`SRP_A_MW_HI, 8'h22);
        `CHK("mw", 16'h2211, mw);
        wr(`SRP_A_MW_LO, 8'h33);
        acc(7'h10, 8'h00, 1'b1, 1'b0, q);
        wr(`SRP_A_MW_HI, 8'h44);
        `CHK("mw cut", 16'h2211, mw);
    endtask : t_multi
    task automatic t_freeze;
        logic [7:0] q;
        acc(`SRP_A_FRQ_LO, 8'h00, 1'b1, 1'b0, q);
        `CHK("frq lo", 8'h45, q);
        freq <= 19'h6789A;
        acc(`SRP_A_FRQ_MID, 8'h00, 1'b1, 1'b0, q);
        `CHK("frq mid", 8'h23, q);
        acc(`SRP_A_FRQ_HI, 8'h00, 1'b1, 1'b0, q);
        `CHK("frq hi", 8'h01, q);
        acc(`SRP_A_FRQ_LO, 8'h00, 1'b1, 1'b0, q);
        `CHK("frq new", 8'h9A, q);
    endtask : t_freeze
    task automatic pulse_lost;
        lost <= 1'b1;
        alarm <= 1'b1;
        @(posedge i_clk_sys);
        lost <= 1'b0;
        alarm <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
    endtask : pulse_lost
    task automatic t_irq;
        logic [7:0] q;
        wr(`SRP_A_MSK_OP, 8'h01);
        wr(`SRP_A_IRQ_CTL, 8'h03);
        `CHK("irq idle", 1'b0, irq);
        op_st <= 3'h2;
        src <= 8'h04;
        pulse_lost();
        `CHK("irq set", 1'b1, irq);
        acc(`SRP_A_STS_OP, 8'h00, 1'b1, 1'b0, q);
        `CHK("sts", 8'h81, q);
        acc(`SRP_A_STS_SRC, 8'h00, 1'b1, 1'b0, q);
        `CHK("sts src", 8'h04, q);
        acc(`SRP_A_STS_SYN, 8'h00, 1'b1, 1'b0, q);
        `CHK("sts syn", 8'h80, q);
        wr(`SRP_A_STS_OP, 8'h80);
        wr(`SRP_A_STS_OP, 8'h00);
        acc(`SRP_A_STS_OP, 8'h00, 1'b1, 1'b0, q);
        `CHK("sts clr", 8'h01, q);
        `CHK("irq held", 1'b1, irq);
        wr(`SRP_A_STS_OP, 8'h01);
        `CHK("irq off", 1'b0, irq);
        wr(`SRP_A_IRQ_CTL, 8'h00);
        `CHK("irq float", 1'b0, lnk.irq_oe);
        pulse_lost();
        `CHK("irq low", 1'b0, irq);
        wr(`SRP_A_STS_OP, 8'h01);
        `CHK("irq high", 1'b1, irq);
    endtask : t_irq
    task automatic t_reset;
        logic [7:0] q;
        i_rst_b <= 1'b0;
        @(posedge i_clk_sys);
        `CHK("rst mw", 16'h0000, mw);
        `CHK("rst ready", 1'b0, ready);
        i_rst_b <= 1'b1;
        // Map has no fixed-value bits to restore
        boot();
        acc(7'h10, 8'h00, 1'b1, 1'b0, q);
        `CHK("rst cfg", `SRP_CFG_RST, q);
        acc(`SRP_A_STRAP, 8'h00, 1'b1, 1'b0, q);
        `CHK("strap", 8'h05, q);
    endtask : t_reset
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        boot();
        t_regs();
        t_multi();
        t_freeze();
        t_irq();
        t_reset();
        final_report();
    end
endmodule : tb
`default_nettype wire
